// [common/eeprom_pkg.sv]
// shared constants, state types and packet check-bit functions of the serial eeprom
package eeprom_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS       = 20;
	localparam int unsigned WRITE_CYCLE_TIME_NS = 5000000;
	localparam int unsigned WRITE_CYCLE_CLKS    = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// geometry
	// ---------------------------------------------------------------
	localparam int          ADDR_W    = 16;
	localparam int          PAGE_W    = 7;
	localparam int          BYTE_W    = 8;
	localparam int          DATA_W    = 32;
	localparam int          ECC_W     = 6;
	localparam int          CODE_LEN  = DATA_W + ECC_W;
	localparam int          BUF_DEPTH = 2;
	localparam int          LOAD_W    = PAGE_W + BYTE_W;
	localparam logic [3:0]  BYTE_BITS = 4'h8;
	localparam logic [7:0]  ERASED    = 8'hff;
	// arbitrary value, not a real type identifier
	localparam logic [3:0]  DEFAULT_TYPE_ID = 4'h5;

	// ---------------------------------------------------------------
	// states
	// ---------------------------------------------------------------
	typedef enum {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_RACK} link_st_t;
	typedef enum {BK_DEV, BK_AH, BK_AL, BK_DATA} byte_kind_t;

	// ---------------------------------------------------------------
	// hamming check bits: xor of the codeword positions of set data bits
	// ---------------------------------------------------------------
	function automatic logic [ECC_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
		logic [ECC_W-1:0] c;
		int               k;
		c = '0;
		k = 0;
		for (int p = 1; p < CODE_LEN + 1; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (d[k])
					c = c ^ ECC_W'(p);
				k++;
			end
		end
		return c;
	endfunction : ecc_gen

	function automatic logic [DATA_W-1:0] ecc_fix(input logic [CODE_LEN-1:0] w);
		logic [ECC_W-1:0]  syn;
		logic [DATA_W-1:0] d;
		int                k;
		d   = w[DATA_W-1:0];
		syn = w[CODE_LEN-1:DATA_W] ^ ecc_gen(d);
		k   = 0;
		for (int p = 1; p < CODE_LEN + 1; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (ECC_W'(p) == syn)
					d[k] = ~d[k];
				k++;
			end
		end
		return d;
	endfunction : ecc_fix

endpackage : eeprom_pkg

// [common/stream_if.sv]
// valid/ready byte stream between the link engine, its buffer and the array
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : stream_if

// [verilog/stream_buffer.sv]
// small valid/ready buffer in the write data path
`timescale 1ns/1ps
module stream_buffer import eeprom_pkg::*; #(
	parameter int W     = LOAD_W,
	parameter int DEPTH = BUF_DEPTH
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	stream_if.snk     fill_in,
	stream_if.src     drain_out
);
	// depth must be a power of two so the pointers wrap by themselves
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0]  mem_r [DEPTH];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [PW:0]   cnt_r, cnt_nxt;
	logic          push, pop;

	assign fill_in.ready   = cnt_r != (PW+1)'(DEPTH);
	assign drain_out.valid = cnt_r != '0;
	assign drain_out.data  = mem_r[rp_r];

	always_comb begin
		push    = fill_in.valid && fill_in.ready;
		pop     = drain_out.valid && drain_out.ready;
		wp_nxt  = push ? wp_r + 1'b1 : wp_r;
		rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (push)
			mem_r[wp_r] <= fill_in.data;
	end

endmodule : stream_buffer

// [verilog/eeprom_array.sv]
// packet store with check bits, page latch and the read-modify-write commit
`timescale 1ns/1ps
module eeprom_array import eeprom_pkg::*; #(
	parameter int AW = ADDR_W,
	parameter int PW = PAGE_W
) (
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	stream_if.snk                   load_in,
	input  wire logic               clear_in,
	input  wire logic               commit_in,
	input  wire logic [AW-PW-1:0]   row_in,
	input  wire logic [AW-1:0]      rd_addr_in,
	output logic                    busy_out,
	output logic [BYTE_W-1:0]       rd_data_out
);
	localparam int WA   = AW - 2;
	localparam int PKW  = PW - 2;
	localparam int PAGE = 1 << PW;

	logic [CODE_LEN-1:0] mem [1 << WA];
	logic [BYTE_W-1:0]   lat_r [PAGE];
	logic [PAGE-1:0]     mask_r, mask_nxt;
	logic [CODE_LEN-1:0] word_r;
	logic [1:0]          sel_r;
	logic [BYTE_W-1:0]   rd_data_nxt;
	logic                busy_nxt, phase_r, phase_nxt;
	logic [PKW-1:0]      pk_r, pk_nxt;
	logic [AW-PW-1:0]    row_r, row_nxt;
	logic [WA-1:0]       maddr;
	logic [DATA_W-1:0]   fixed, merged;
	logic                touched, ld;

	// erased array reads all ones with consistent check bits
	initial begin
		for (int i = 0; i < (1 << WA); i++)
			mem[i] = {ecc_gen({4{ERASED}}), {4{ERASED}}};
	end

	// ---------------------------------------------------------------
	// read path and packet merge
	// ---------------------------------------------------------------
	assign load_in.ready = !busy_out;
	assign maddr = busy_out ? {row_r, pk_r} : rd_addr_in[AW-1:2];

	always_comb begin
		fixed   = ecc_fix(word_r);
		touched = 1'b0;
		for (int b = 0; b < 4; b++) begin
			merged[b*BYTE_W +: BYTE_W] = mask_r[{pk_r, 2'(b)}] ? lat_r[{pk_r, 2'(b)}]
			                                                 : fixed[b*BYTE_W +: BYTE_W];
			touched = touched | mask_r[{pk_r, 2'(b)}];
		end
		rd_data_nxt = fixed[{sel_r, 3'h0} +: BYTE_W];
	end

	// ---------------------------------------------------------------
	// commit sequencer: read packet, then write merged packet back
	// ---------------------------------------------------------------
	always_comb begin
		ld        = load_in.valid && !busy_out;
		busy_nxt  = busy_out;
		phase_nxt = phase_r;
		pk_nxt    = pk_r;
		row_nxt   = row_r;
		mask_nxt  = mask_r;
		if (ld)
			mask_nxt[load_in.data[LOAD_W-1:BYTE_W]] = 1'b1;
		if (clear_in)
			mask_nxt = '0;
		if (!busy_out && commit_in) begin
			busy_nxt  = 1'b1;
			phase_nxt = 1'b0;
			pk_nxt    = '0;
			row_nxt   = row_in;
		end else if (busy_out) begin
			phase_nxt = !phase_r;
			if (phase_r) begin
				pk_nxt = pk_r + 1'b1;
				if (pk_r == '1) begin
					busy_nxt = 1'b0;
					mask_nxt = '0;
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			busy_out    <= 1'b0;
			phase_r     <= 1'b0;
			pk_r        <= '0;
			row_r       <= '0;
			mask_r      <= '0;
			sel_r       <= '0;
			rd_data_out <= '0;
		end else begin
			busy_out    <= busy_nxt;
			phase_r     <= phase_nxt;
			pk_r        <= pk_nxt;
			row_r       <= row_nxt;
			mask_r      <= mask_nxt;
			sel_r       <= rd_addr_in[1:0];
			rd_data_out <= rd_data_nxt;
		end
	end

	// whole packet and its check bits are rewritten together
	always_ff @(posedge clk_in) begin
		word_r <= mem[maddr];
		if (busy_out && phase_r && touched)
			mem[maddr] <= {ecc_gen(merged), merged};
		if (ld)
			lat_r[load_in.data[LOAD_W-1:BYTE_W]] <= load_in.data[BYTE_W-1:0];
	end

	a_commit_span : assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(busy_out) |-> busy_out[*8])
		else $error("commit ended too early");

endmodule : eeprom_array

// [verilog/eeprom_link.sv]
// two-wire slave engine of the serial eeprom: select, address, write and read
`timescale 1ns/1ps
module eeprom_link import eeprom_pkg::*; #(
	parameter int unsigned WRITE_CYCLES = WRITE_CYCLE_CLKS,
	parameter logic [3:0]  TYPE_ID      = DEFAULT_TYPE_ID,
	parameter int          PAGE_BITS    = PAGE_W
) (
	input  wire logic clock_in,
	input  wire logic rst_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out_out,
	output logic      sda_oe_n_out,
	input  wire logic strap_addr_bit0_in,
	input  wire logic strap_addr_bit1_in,
	input  wire logic strap_addr_bit2_in,
	input  wire logic write_protect_in,
	output logic      busy_out
);
	// ---------------------------------------------------------------
	// pin synchronisers, clock and data edge detection
	// ---------------------------------------------------------------
	logic       scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, wp_m, wp_s;
	logic [2:0] strap_m, strap_s;
	logic       scl_rise, scl_fall, start_det, stop_det;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			{scl_m, scl_s, scl_d} <= 3'h7;
			{sda_m, sda_s, sda_d} <= 3'h7;
			{wp_m, wp_s}          <= 2'h0;
			strap_m               <= 3'h0;
			strap_s               <= 3'h0;
		end else begin
			scl_m   <= scl_in;
			scl_s   <= scl_m;
			scl_d   <= scl_s;
			sda_m   <= sda_in;
			sda_s   <= sda_m;
			sda_d   <= sda_s;
			wp_m    <= write_protect_in;
			wp_s    <= wp_m;
			strap_m <= {strap_addr_bit2_in, strap_addr_bit1_in, strap_addr_bit0_in};
			strap_s <= strap_m;
		end
	end

	// relies on the master changing data only while clock is low
	assign scl_rise  = scl_s && !scl_d;
	assign scl_fall  = !scl_s && scl_d;
	assign start_det = scl_s && scl_d && sda_d && !sda_s;
	assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

	// ---------------------------------------------------------------
	// write data buffer and packet store
	// ---------------------------------------------------------------
	stream_if #(.W(LOAD_W)) load_fill ();
	stream_if #(.W(LOAD_W)) load_drain ();

	logic              push_r, push_nxt, clear_r, clear_nxt, commit_r, commit_nxt, arr_busy;
	logic [LOAD_W-1:0] pdata_r, pdata_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [BYTE_W-1:0] rd_byte;

	assign load_fill.valid = push_r;
	assign load_fill.data  = pdata_r;

	stream_buffer #(.W(LOAD_W), .DEPTH(BUF_DEPTH)) u_buf (
		.clk_in    (clock_in),
		.rst_in    (rst_in),
		.fill_in   (load_fill),
		.drain_out (load_drain)
	);

	eeprom_array #(.AW(ADDR_W), .PW(PAGE_BITS)) u_arr (
		.clk_in      (clock_in),
		.rst_in      (rst_in),
		.load_in     (load_drain),
		.clear_in    (clear_r),
		.commit_in   (commit_r),
		.row_in      (addr_r[ADDR_W-1:PAGE_BITS]),
		.rd_addr_in  (addr_r),
		.busy_out    (arr_busy),
		.rd_data_out (rd_byte)
	);

	// ---------------------------------------------------------------
	// link state machine
	// ---------------------------------------------------------------
	link_st_t          st_r, st_nxt;
	byte_kind_t        kind_r, kind_nxt;
	logic [3:0]        cnt_r, cnt_nxt;
	logic [BYTE_W-1:0] sh_r, sh_nxt;
	logic              rw_r, rw_nxt, wpl_r, wpl_nxt, slot10_r, slot10_nxt;
	logic              loaded_r, loaded_nxt, oe_n_nxt, busy_nxt, match;
	logic [31:0]       bcnt_r, bcnt_nxt;

	assign match = sh_r[7:4] == TYPE_ID && sh_r[3:1] == strap_s;

	always_comb begin
		st_nxt     = st_r;
		kind_nxt   = kind_r;
		cnt_nxt    = cnt_r;
		sh_nxt     = sh_r;
		rw_nxt     = rw_r;
		wpl_nxt    = wpl_r;
		slot10_nxt = slot10_r;
		loaded_nxt = loaded_r;
		addr_nxt   = addr_r;
		oe_n_nxt   = sda_oe_n_out;
		busy_nxt   = busy_out;
		bcnt_nxt   = bcnt_r;
		push_nxt   = 1'b0;
		pdata_nxt  = pdata_r;
		clear_nxt  = 1'b0;
		commit_nxt = 1'b0;
		if (busy_out) begin
			// deaf and released while the array is written
			st_nxt   = ST_IDLE;
			oe_n_nxt = 1'b1;
			if (bcnt_r != '0)
				bcnt_nxt = bcnt_r - 1'b1;
			else if (!arr_busy && !commit_r)
				busy_nxt = 1'b0;
		end else if (start_det) begin // repeated start of a random read too
			st_nxt     = ST_RECV;
			kind_nxt   = BK_DEV;
			cnt_nxt    = '0;
			wpl_nxt    = wp_s;
			slot10_nxt = 1'b0;
			oe_n_nxt   = 1'b1;
		end else if (stop_det) begin
			st_nxt     = ST_IDLE;
			oe_n_nxt   = 1'b1;
			slot10_nxt = 1'b0;
			if (slot10_r && loaded_r) begin
				commit_nxt = 1'b1;
				busy_nxt   = 1'b1;
				bcnt_nxt   = WRITE_CYCLES;
				loaded_nxt = 1'b0;
			end
		end else begin
			if (st_r != ST_IDLE && kind_r != BK_DATA && wp_s)
				wpl_nxt = 1'b1;
			case (st_r)
				ST_RECV: begin
					if (scl_rise) begin
						sh_nxt  = {sh_r[6:0], sda_s};
						cnt_nxt = cnt_r + 1'b1;
					end else if (scl_fall && cnt_r == BYTE_BITS) begin
						st_nxt  = ST_ACK;
						cnt_nxt = '0;
						case (kind_r)
							BK_DEV: begin
								if (match) begin
									oe_n_nxt = 1'b0;
									rw_nxt   = sh_r[0];
									kind_nxt = BK_AH;
									if (!sh_r[0]) begin
										clear_nxt  = 1'b1;
										loaded_nxt = 1'b0;
									end
								end else begin
									st_nxt = ST_IDLE;
								end
							end
							BK_AH: begin
								oe_n_nxt              = 1'b0;
								addr_nxt[ADDR_W-1:BYTE_W] = sh_r;
								kind_nxt              = BK_AL;
							end
							BK_AL: begin
								oe_n_nxt              = 1'b0;
								addr_nxt[BYTE_W-1:0]  = sh_r;
								kind_nxt              = BK_DATA;
							end
							BK_DATA: begin
								if (!wpl_r && load_fill.ready) begin
									oe_n_nxt   = 1'b0;
									push_nxt   = 1'b1;
									pdata_nxt  = {addr_r[PAGE_BITS-1:0], sh_r};
									loaded_nxt = 1'b1;
									// row bits held, low bits wrap
									addr_nxt[PAGE_BITS-1:0] = addr_r[PAGE_BITS-1:0] + 1'b1;
								end
							end
							default: st_nxt = ST_IDLE;
						endcase
					end else if (scl_fall) begin
						// a stop needs the tenth clock high, so the slot closes on its fall
						slot10_nxt = 1'b0;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (rw_r) begin
							// reads ignore write protect
							st_nxt   = ST_SEND;
							sh_nxt   = rd_byte;
							oe_n_nxt = rd_byte[7];
							cnt_nxt  = 4'h1;
						end else begin
							st_nxt     = ST_RECV;
							oe_n_nxt   = 1'b1;
							slot10_nxt = kind_r == BK_DATA;
						end
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						if (cnt_r == BYTE_BITS) begin
							st_nxt   = ST_RACK;
							oe_n_nxt = 1'b1;
							addr_nxt = addr_r + 1'b1;
						end else begin
							oe_n_nxt = sh_r[6];
							sh_nxt   = {sh_r[6:0], 1'b0};
							cnt_nxt  = cnt_r + 1'b1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise)
						st_nxt = sda_s ? ST_IDLE : ST_ACK;
				end
				default: st_nxt = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st_r         <= ST_IDLE;
			kind_r       <= BK_DEV;
			cnt_r        <= '0;
			sh_r         <= '0;
			rw_r         <= 1'b0;
			wpl_r        <= 1'b0;
			slot10_r     <= 1'b0;
			loaded_r     <= 1'b0;
			addr_r       <= '0;
			sda_oe_n_out <= 1'b1;
			sda_out_out  <= 1'b0;
			busy_out     <= 1'b0;
			bcnt_r       <= '0;
			push_r       <= 1'b0;
			pdata_r      <= '0;
			clear_r      <= 1'b0;
			commit_r     <= 1'b0;
		end else begin
			st_r         <= st_nxt;
			kind_r       <= kind_nxt;
			cnt_r        <= cnt_nxt;
			sh_r         <= sh_nxt;
			rw_r         <= rw_nxt;
			wpl_r        <= wpl_nxt;
			slot10_r     <= slot10_nxt;
			loaded_r     <= loaded_nxt;
			addr_r       <= addr_nxt;
			sda_oe_n_out <= oe_n_nxt;
			sda_out_out  <= 1'b0;
			busy_out     <= busy_nxt;
			bcnt_r       <= bcnt_nxt;
			push_r       <= push_nxt;
			pdata_r      <= pdata_nxt;
			clear_r      <= clear_nxt;
			commit_r     <= commit_nxt;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	sequence s_select_end;
		!busy_out && !start_det && !stop_det && st_r == ST_RECV && kind_r == BK_DEV
			&& scl_fall && cnt_r == BYTE_BITS;
	endsequence

	sequence s_data_end;
		!busy_out && !start_det && !stop_det && st_r == ST_RECV && kind_r == BK_DATA
			&& scl_fall && cnt_r == BYTE_BITS;
	endsequence

	a_select_ack : assert property (s_select_end and match |=> !sda_oe_n_out)
		else $error("matching select not acknowledged");
	a_select_miss : assert property (s_select_end and !match |=> sda_oe_n_out && st_r == ST_IDLE)
		else $error("mismatched select not released");
	a_wp_refuse : assert property (s_data_end and wpl_r |=> sda_oe_n_out && !push_r)
		else $error("protected data byte accepted");
	a_busy_quiet : assert property (busy_out |-> ##1 sda_oe_n_out)
		else $error("driver active during write cycle");
	a_stop_slot : assert property (stop_det && !slot10_r && !busy_out |=> !busy_out)
		else $error("write started outside tenth slot");
	a_stop_commit : assert property (stop_det && slot10_r && loaded_r && !busy_out
		|=> busy_out && commit_r)
		else $error("stop in tenth slot did not start the write");
	a_row_held : assert property (push_r |-> addr_r[ADDR_W-1:PAGE_BITS]
		== $past(addr_r[ADDR_W-1:PAGE_BITS]))
		else $error("page load changed row bits");
	a_rise_sample : assert property (st_r == ST_RECV && scl_rise && !busy_out && !start_det
		&& !stop_det |=> sh_r[0] == $past(sda_s))
		else $error("data bit not taken on clock rise");
	a_busy_hold : assert property ($rose(busy_out) |-> busy_out[*8] ##1 commit_r == 1'b0)
		else $error("write cycle too short");

endmodule : eeprom_link

// [sim/i2c_master_model.sv]
// behavioural two-wire bus master that drives the clock and pulls the data line
`timescale 1ns/1ps
module i2c_master_model (
	input  wire logic clock_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	// the bus clock stands high outside frames; one bit is 8 system clocks
	initial begin
		scl_out     = 1'b1;
		sda_low_out = 1'b0;
	end

	task automatic q;
		repeat (2) @(posedge clock_in);
	endtask : q

	// ---------------------------------------------------------------
	// conditions
	// ---------------------------------------------------------------
	// low phase is stretched so a late ack release is never seen as a stop
	task automatic start;
		sda_low_out <= 1'b0;
		q();
		q();
		q();
		scl_out <= 1'b1;
		q();
		sda_low_out <= 1'b1;
		q();
		scl_out <= 1'b0;
	endtask : start

	task automatic stop;
		q();
		sda_low_out <= 1'b1;
		q();
		scl_out <= 1'b1;
		q();
		sda_low_out <= 1'b0;
		q();
	endtask : stop

	// ---------------------------------------------------------------
	// bits and bytes
	// ---------------------------------------------------------------
	task automatic bit_cycle(input logic b, output logic s);
		q();
		sda_low_out <= ~b;
		q();
		scl_out <= 1'b1;
		q();
		s = sda_in;
		q();
		scl_out <= 1'b0;
	endtask : bit_cycle

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(b[i], s);
		end
		bit_cycle(1'b1, s);
		ack = ~s;
	endtask : send_byte

	task automatic recv_byte(input logic mack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b1, s);
			b[i] = s;
		end
		bit_cycle(~mack, s);
	endtask : recv_byte
endmodule : i2c_master_model

// [sim/eeprom_link_tb.sv]
// self-checking bench of the eeprom two-wire slave engine
`timescale 1ns/1ps
module eeprom_link_tb;
	import eeprom_pkg::*;
	localparam int unsigned WC = 200;
	logic       clock_in;
	logic       rst_in;
	logic       wp;
	logic [2:0] strap;
	logic       scl;
	logic       sda_low;
	logic       sda_out;
	logic       sda_oe_n;
	logic       busy;
	int         n_errors;
	int         n_compared;
	// open-drain wire with pull-up
	wire logic  sda = sda_low ? 1'b0 : (!sda_oe_n ? sda_out : 1'b1);

	eeprom_link #(.WRITE_CYCLES(WC)) DUT (
		.clock_in          (clock_in),
		.rst_in            (rst_in),
		.scl_in            (scl),
		.sda_in            (sda),
		.sda_out_out       (sda_out),
		.sda_oe_n_out      (sda_oe_n),
		.strap_addr_bit0_in(strap[0]),
		.strap_addr_bit1_in(strap[1]),
		.strap_addr_bit2_in(strap[2]),
		.write_protect_in  (wp),
		.busy_out          (busy)
	);

	i2c_master_model m (
		.clock_in   (clock_in),
		.sda_in     (sda),
		.scl_out    (scl),
		.sda_low_out(sda_low)
	);

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	task automatic sel(input logic rw, input logic exp);
		logic ack;
		m.start();
		m.send_byte({DEFAULT_TYPE_ID, strap, rw}, ack);
		check({7'h0, ack}, {7'h0, exp});
	endtask : sel

	task automatic set_addr(input logic [15:0] a);
		logic ack;
		sel(1'b0, 1'b1);
		m.send_byte(a[15:8], ack);
		check({7'h0, ack}, 8'h01);
		m.send_byte(a[7:0], ack);
		check({7'h0, ack}, 8'h01);
	endtask : set_addr

	task automatic wr(input logic [15:0] a, input logic [7:0] d[$], input logic exp);
		logic ack;
		set_addr(a);
		foreach (d[i]) begin
			m.send_byte(d[i], ack);
			check({7'h0, ack}, {7'h0, exp});
		end
		m.stop();
	endtask : wr

	task automatic rd(input logic rnd, input logic [15:0] a, input logic [7:0] e[$]);
		logic [7:0] b;
		if (rnd)
			set_addr(a);
		sel(1'b1, 1'b1);
		foreach (e[i]) begin
			m.recv_byte(i != e.size() - 1, b);
			check(b, e[i]);
		end
		m.stop();
	endtask : rd

	// a poll issued while busy must see no ack
	task automatic wait_write(input logic poll);
		int n;
		n = 0;
		while (busy !== 1'b1 && n < 20) begin
			@(posedge clock_in);
			n++;
		end
		check({7'h0, busy}, 8'h01);
		if (poll) begin
			sel(1'b0, 1'b0);
			m.stop();
		end
		n = 0;
		while (busy !== 1'b0 && n < WC + 100) begin
			@(posedge clock_in);
			n++;
		end
		check({7'h0, busy}, 8'h00);
		repeat (8) @(posedge clock_in);
	endtask : wait_write

	task automatic no_write;
		logic seen;
		seen = 1'b0;
		repeat (30) begin
			@(posedge clock_in);
			seen = seen | busy;
		end
		check({7'h0, seen}, 8'h00);
	endtask : no_write

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_select;
		logic [7:0] b;
		logic       ack;
		for (int k = 0; k < 5; k++) begin
			b = {DEFAULT_TYPE_ID, strap, 1'b0};
			if (k == 1)
				b[7:4] = DEFAULT_TYPE_ID ^ 4'h8;
			if (k > 1)
				b[k-1] = ~b[k-1];
			m.start();
			m.send_byte(b, ack);
			check({7'h0, ack}, {7'h0, k == 0});
			if (k != 0) begin
				m.send_byte({DEFAULT_TYPE_ID, strap, 1'b0}, ack);
				check({7'h0, ack}, 8'h00);
			end
			m.stop();
		end
		no_write();
	endtask : t_select

	task automatic t_write;
		wr(16'h1235, '{8'h5a}, 1'b1);
		wait_write(1'b1);
		wr(16'h1234, '{8'ha5}, 1'b1);
		wait_write(1'b0);
		rd(1'b0, 16'h0000, '{8'h5a});
		rd(1'b1, 16'h1234, '{8'ha5, 8'h5a, 8'hff});
	endtask : t_write

	task automatic t_protect;
		wp <= 1'b1;
		wr(16'h1236, '{8'h77, 8'h78}, 1'b0);
		no_write();
		rd(1'b1, 16'h1236, '{8'hff});
		wp <= 1'b0;
		set_addr(16'h1236);
		m.stop();
		no_write();
	endtask : t_protect

	task automatic t_page;
		wr(16'h037e, '{8'h11, 8'h22, 8'h33, 8'h44}, 1'b1);
		wait_write(1'b0);
		rd(1'b1, 16'h0300, '{8'h33, 8'h44});
		rd(1'b1, 16'h037e, '{8'h11, 8'h22});
	endtask : t_page

	// ---------------------------------------------------------------
	// clock, reset, sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end

	initial begin
		n_errors   = 0;
		n_compared = 0;
		rst_in     = 1'b1;
		wp         = 1'b0;
		strap      = 3'h5;
		repeat (6) @(posedge clock_in);
		rst_in <= 1'b0;
		repeat (6) @(posedge clock_in);
		t_select();
		t_write();
		t_protect();
		t_page();
		conclude();
	end

	// the sequence needs well under 15000 cycles
	initial begin
		repeat (40000) @(posedge clock_in);
		n_errors++;
		conclude();
	end
endmodule : eeprom_link_tb
